// ==== dt8_pkg.sv ====
// Shared constants and types for the dual 8-bit timer block.
// Assumes a single 100 MHz clock and a synchronous active-high reset.
package dt8_pkg;
	typedef logic [7:0] dt8_byte_t;
	typedef logic [2:0] dt8_csel_t;
	typedef logic [8:0] dt8_presc_t;

	// -----------------------------------------------------------------
	// Control byte field positions
	// -----------------------------------------------------------------
	localparam int RUN_BIT  = 7;
	localparam int PWM_BIT  = 6;
	localparam int CASC_BIT = 4;
	localparam int LVS_BIT  = 3;
	localparam int LVR_BIT  = 2;
	localparam int ALV_BIT  = 1;
	localparam int OE_BIT   = 0;

	// -----------------------------------------------------------------
	// Count clock selection codes and prescaler masks
	// -----------------------------------------------------------------
	localparam dt8_csel_t CSEL_FALL   = 3'h0;
	localparam dt8_csel_t CSEL_RISE   = 3'h1;
	localparam dt8_csel_t CSEL_DIV4   = 3'h2;
	localparam dt8_csel_t CSEL_DIV8   = 3'h3;
	localparam dt8_csel_t CSEL_DIV16  = 3'h4;
	localparam dt8_csel_t CSEL_DIV32  = 3'h5;
	localparam dt8_csel_t CSEL_DIV128 = 3'h6;
	localparam dt8_presc_t MASK_DIV4   = 9'h003;
	localparam dt8_presc_t MASK_DIV8   = 9'h007;
	localparam dt8_presc_t MASK_DIV16  = 9'h00F;
	localparam dt8_presc_t MASK_DIV32  = 9'h01F;
	localparam dt8_presc_t MASK_DIV128 = 9'h07F;
	localparam dt8_presc_t MASK_DIV512 = 9'h1FF;
	localparam dt8_presc_t PRESC_ZERO  = 9'h000;
	localparam dt8_presc_t PRESC_ONE   = 9'h001;

	// -----------------------------------------------------------------
	// Counter values
	// -----------------------------------------------------------------
	localparam dt8_byte_t CNT_ZERO = 8'h00;
	localparam dt8_byte_t CNT_ONE  = 8'h01;
	localparam dt8_byte_t CNT_MAX  = 8'hFF;
endpackage : dt8_pkg

// ==== dt8_chan_if.sv ====
// Link between the timer top level and one 8-bit counter channel.
// Assumes both ends run on the same clock.
interface dt8_chan_if;
	import dt8_pkg::*;
	logic      tick;      // Count enable pulse, already gated by run
	logic      run;       // Counting enabled
	logic      pwm;       // PWM operation selected
	logic      own_clear; // Clear on own compare match
	logic      ext_clr;   // Clear forced from outside (cascade)
	logic      cmp_wr;    // Compare write strobe
	dt8_byte_t cmp_wdata; // Compare write data
	logic      act_lvl;   // PWM active level
	logic      out_en;    // Output pin enabled
	logic      lvs;       // Preset output flip-flop high
	logic      lvr;       // Preset output flip-flop low
	dt8_byte_t count;     // Current count
	dt8_byte_t cmp_rd;    // Compare value as read back
	logic      eq;        // Count equals compare
	logic      hit;       // Match on a count pulse, not write-masked
	logic      ovf;       // Count pulse while at top value
	logic      wave;      // Output pin level

	modport top (output tick, run, pwm, own_clear, ext_clr, cmp_wr,
		cmp_wdata, act_lvl, out_en, lvs, lvr,
		input count, cmp_rd, eq, hit, ovf, wave);
	modport chan (input tick, run, pwm, own_clear, ext_clr, cmp_wr,
		cmp_wdata, act_lvl, out_en, lvs, lvr,
		output count, cmp_rd, eq, hit, ovf, wave);
endinterface : dt8_chan_if

// ==== dt8_chan.sv ====
// One 8-bit counter channel: counter, compare register, output flip-flop.
// Assumes the top level supplies a run-gated count pulse.
module dt8_chan (
	// Clock and reset
	input  wire logic clk,
	input  wire logic sys_rst,
	// Channel link
	dt8_chan_if.chan  c
);
	import dt8_pkg::*;

	dt8_byte_t count, next_count;
	dt8_byte_t cmp, next_cmp;
	dt8_byte_t cmp_rd, next_cmp_rd;
	logic      ff, next_ff;
	logic      pin, next_pin;
	logic      clr_evt;

	// -----------------------------------------------------------------
	// Match and overflow detection
	// -----------------------------------------------------------------
	// A write landing on the match cycle masks that match entirely
	assign c.eq  = (count == cmp);
	assign c.hit = c.tick & c.eq & ~c.cmp_wr;
	assign c.ovf = c.tick & (count == CNT_MAX);
	// PWM never clears on its own match; only the cascade clear stops its run to overflow
	assign clr_evt = c.tick & (c.ext_clr
		| (c.own_clear & ~c.pwm & c.hit));
	assign c.count  = count;
	assign c.cmp_rd = cmp_rd;
	assign c.wave   = pin;

	// Next state of counter, compare and output
	always_comb begin
		next_count  = count;
		next_cmp    = cmp;
		next_cmp_rd = cmp_rd;
		next_ff     = ff;
		// Direct write; a repeat write at overflow just lands
		if (c.cmp_wr) begin
			next_cmp = c.cmp_wdata;
		end
		// Read copy frozen on the overflow cycle
		if (!c.ovf) begin
			next_cmp_rd = cmp;
		end
		if (!c.run) begin
			next_count = CNT_ZERO;
			if (c.pwm) begin
				next_ff = 1'b0;
			end else if (c.lvs) begin
				next_ff = 1'b1;
			end else if (c.lvr) begin
				next_ff = 1'b0;
			end
		end else if (c.tick) begin
			// Past a lowered compare the count wraps through zero
			if (clr_evt) begin
				next_count = CNT_ZERO;
			end else begin
				next_count = count + CNT_ONE;
			end
			if (c.pwm) begin
				if (c.ovf) begin
					next_ff = 1'b1;
				end else if (c.hit) begin
					next_ff = 1'b0;
				end
			end else if (clr_evt) begin
				next_ff = ~ff;
			end
		end
		next_pin = c.out_en & (c.pwm ? (ff ? c.act_lvl : ~c.act_lvl) : ff);
	end

	// Register channel state
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			count  <= CNT_ZERO;
			cmp    <= CNT_ZERO;
			cmp_rd <= CNT_ZERO;
			ff     <= 1'b0;
			pin    <= 1'b0;
		end else begin
			count  <= next_count;
			cmp    <= next_cmp;
			cmp_rd <= next_cmp_rd;
			ff     <= next_ff;
			pin    <= next_pin;
		end
	end
endmodule : dt8_chan

// ==== dt8_timer.sv ====
// Dual 8-bit timer/counter with cascade into one 16-bit interval timer.
// Assumes control bytes and clock selects are held steady by software
// and that compare writes and count reads arrive as one-cycle strobes.
//
// Overview of operation
// - Cascade select bit 4 of control b joins both counters as 16 bits.
// - Cascade: both counters matching raises irq a and clears both.
// - Each compare byte accepts any value 00 to FF in cascade.
// - In cascade, run a low stops the whole 16-bit count; starting it needs run b as well.
// - Counter b still raises irq b in cascade, on the combined 16-bit match; software masks it.
// - Start is unsynchronised to count pulse; first match may slip one.
// - Compare lowered below count: counter wraps through zero, no match.
// - Reading a running counter suspends its count pulse briefly.
// - Interval or square: compare write at match suppresses the irq.
// - Clear-on-match: compare write at match leaves counter uncleared.
// - Square wave: compare write at match leaves output uninverted.
// - PWM: compare write at match suppresses the match signal.
// - PWM: irq fires on counter overflow, not on compare match.
// - PWM: second compare write at overflow simply lands like any other write.
// - PWM: compare read on overflow cannot show the pre-overflow write.
// - Clock field: ext fall, ext rise, then /4 /8 /16 /32 /128 /512.
// - Run bit 7 high counts, low stops.
// - PWM bit 6: active from overflow until match, inactive otherwise.
// - PWM output inactive from start to first overflow and when stopped.
module dt8_timer (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              sys_rst,
	// Control bytes and clock selects
	input  wire dt8_pkg::dt8_byte_t ctrl_a,
	input  wire dt8_pkg::dt8_byte_t ctrl_b,
	input  wire dt8_pkg::dt8_csel_t clock_select_a,
	input  wire dt8_pkg::dt8_csel_t clock_select_b,
	// Compare write and count read strobes
	input  wire logic              compare_wr_a,
	input  wire logic              compare_wr_b,
	input  wire dt8_pkg::dt8_byte_t compare_wdata,
	input  wire logic              count_rd_a,
	input  wire logic              count_rd_b,
	// External event pins
	input  wire logic              event_in_a,
	input  wire logic              event_in_b,
	// Read-back values
	output dt8_pkg::dt8_byte_t     count_reg_a,
	output dt8_pkg::dt8_byte_t     count_reg_b,
	output dt8_pkg::dt8_byte_t     compare_a,
	output dt8_pkg::dt8_byte_t     compare_b,
	// Interrupt pulses and output pins
	output logic                   match_irq_a,
	output logic                   match_irq_b,
	output logic                   wave_out_a,
	output logic                   wave_out_b
);
	import dt8_pkg::*;

	localparam int NCH = 2;

	// -----------------------------------------------------------------
	// Count clock selection
	// -----------------------------------------------------------------
	function automatic logic sel_tick(input dt8_csel_t sel,
		input dt8_presc_t p, input logic fall, input logic rise);
		dt8_presc_t m;
		m = MASK_DIV512;
		if (sel == CSEL_DIV4) begin
			m = MASK_DIV4;
		end else if (sel == CSEL_DIV8) begin
			m = MASK_DIV8;
		end else if (sel == CSEL_DIV16) begin
			m = MASK_DIV16;
		end else if (sel == CSEL_DIV32) begin
			m = MASK_DIV32;
		end else if (sel == CSEL_DIV128) begin
			m = MASK_DIV128;
		end
		if (sel == CSEL_FALL) begin
			sel_tick = fall;
		end else if (sel == CSEL_RISE) begin
			sel_tick = rise;
		end else begin
			sel_tick = ((p & m) == m);
		end
	endfunction : sel_tick

	dt8_chan_if ch [NCH] ();

	dt8_presc_t presc, next_presc;
	logic [2:0] sync [NCH];
	logic [2:0] next_sync [NCH];
	logic       irq_a, next_irq_a;
	logic       irq_b, next_irq_b;
	dt8_byte_t  ctrl [NCH];
	dt8_csel_t  csel [NCH];
	logic       pin_in [NCH];
	logic       rd [NCH];
	logic       wr [NCH];
	logic       base_tick [NCH];
	logic       casc;
	logic       run_a;
	logic       run_b;
	logic       both_hit;

	assign ctrl[0]   = ctrl_a;
	assign ctrl[1]   = ctrl_b;
	assign csel[0]   = clock_select_a;
	assign csel[1]   = clock_select_b;
	assign pin_in[0] = event_in_a;
	assign pin_in[1] = event_in_b;
	assign rd[0]     = count_rd_a;
	assign rd[1]     = count_rd_b;
	assign wr[0]     = compare_wr_a;
	assign wr[1]     = compare_wr_b;

	// -----------------------------------------------------------------
	// Free-running prescaler
	// -----------------------------------------------------------------
	// Never reset by run, so a start lands anywhere in a pulse period
	always_comb begin
		next_presc = presc + PRESC_ONE;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			presc <= PRESC_ZERO;
		end else begin
			presc <= next_presc;
		end
	end

	// -----------------------------------------------------------------
	// Per-channel pin sync, count pulse and control fan-out
	// -----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			logic rise;
			logic fall;

			// Three-stage synchroniser; stage 0 feeds stage 1 only
			always_comb begin
				next_sync[g] = {sync[g][1:0], pin_in[g]};
			end

			always_ff @(posedge clk) begin
				if (sys_rst) begin
					sync[g] <= 3'h0;
				end else begin
					sync[g] <= next_sync[g];
				end
			end

			assign rise = sync[g][1] & ~sync[g][2];
			assign fall = ~sync[g][1] & sync[g][2];
			// A count read steals the pulse, so slow edges are safest
			assign base_tick[g] = sel_tick(csel[g], presc, fall, rise)
				& ~rd[g];

			assign ch[g].pwm       = ctrl[g][PWM_BIT];
			assign ch[g].cmp_wr    = wr[g];
			assign ch[g].cmp_wdata = compare_wdata;
			assign ch[g].act_lvl   = ctrl[g][ALV_BIT];
			assign ch[g].out_en    = ctrl[g][OE_BIT];
			assign ch[g].lvs       = ctrl[g][LVS_BIT];
			assign ch[g].lvr       = ctrl[g][LVR_BIT];

			dt8_chan u_chan (
				.clk     (clk),
				.sys_rst (sys_rst),
				.c       (ch[g])
			);
		end
	endgenerate

	// -----------------------------------------------------------------
	// Cascade joining
	// -----------------------------------------------------------------
	assign casc  = ctrl_b[CASC_BIT];
	assign run_a = ctrl_a[RUN_BIT];
	// Counter b also needs run a in cascade, so run a rules both
	assign run_b = ctrl_b[RUN_BIT] & (~casc | run_a);
	// Combined match needs both bytes equal and neither compare written
	assign both_hit = casc & ch[0].tick & ch[0].eq & ch[1].eq
		& ~compare_wr_a & ~compare_wr_b;

	assign ch[0].run       = run_a;
	assign ch[0].tick      = base_tick[0] & run_a;
	assign ch[0].own_clear = ~casc;
	assign ch[0].ext_clr   = both_hit;
	assign ch[1].run       = run_b;
	// Upper byte steps on each lower wrap and clears with the pair
	assign ch[1].tick      = casc
		? (ch[0].tick & ((ch[0].count == CNT_MAX) | both_hit)) & run_b
		: base_tick[1] & run_b;
	assign ch[1].own_clear = ~casc;
	assign ch[1].ext_clr   = both_hit;

	// -----------------------------------------------------------------
	// Interrupt pulses
	// -----------------------------------------------------------------
	always_comb begin
		if (ch[0].pwm) begin
			next_irq_a = ch[0].ovf;
		end else if (casc) begin
			next_irq_a = both_hit;
		end else begin
			next_irq_a = ch[0].hit;
		end
		if (ch[1].pwm) begin
			next_irq_b = ch[1].ovf;
		end else if (casc) begin
			// Upper byte reports the combined 16-bit match, like irq a
			next_irq_b = both_hit;
		end else begin
			next_irq_b = ch[1].hit;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq_a <= 1'b0;
			irq_b <= 1'b0;
		end else begin
			irq_a <= next_irq_a;
			irq_b <= next_irq_b;
		end
	end

	// -----------------------------------------------------------------
	// Outputs
	// -----------------------------------------------------------------
	assign match_irq_a = irq_a;
	assign match_irq_b = irq_b;
	assign count_reg_a = ch[0].count;
	assign count_reg_b = ch[1].count;
	assign compare_a   = ch[0].cmp_rd;
	assign compare_b   = ch[1].cmp_rd;
	assign wave_out_a  = ch[0].wave;
	assign wave_out_b  = ch[1].wave;
endmodule : dt8_timer

// ==== dt8_event_src.sv ====
// Pin-side model of the external event sources.
// Assumes one request pulse per wanted rising and falling edge.
module dt8_event_src (
	// Clock
	input  wire logic clk,
	// Request and pin
	input  wire logic req,
	output wire logic pin
);
	timeunit 1ns;
	timeprecision 1ns;
	int hold = 0;

	// Countdown gives four cycles high, then four low
	always @(posedge clk) begin
		hold <= req ? 8 : (hold > 0 ? hold - 1 : 0);
	end
	// Wide levels so the pin synchroniser cannot miss an edge
	assign pin = hold > 4;
endmodule : dt8_event_src

// ==== dt8_asserts.sv ====
// Port-level checks for the dual timer top level.
// Assumes one clock domain; bound into every timer instance.
module dt8_asserts (
	// Clock and reset
	input wire logic               clk,
	input wire logic               sys_rst,
	// Controls and strobes
	input wire dt8_pkg::dt8_byte_t ctrl_a,
	input wire dt8_pkg::dt8_byte_t ctrl_b,
	input wire logic               compare_wr_a,
	input wire dt8_pkg::dt8_byte_t compare_wdata,
	input wire logic               count_rd_a,
	// Observed outputs
	input wire dt8_pkg::dt8_byte_t count_reg_a,
	input wire dt8_pkg::dt8_byte_t count_reg_b,
	input wire dt8_pkg::dt8_byte_t compare_a,
	input wire logic               match_irq_a,
	input wire logic               wave_out_a
);
	timeunit 1ns;
	timeprecision 1ns;
	import dt8_pkg::*;
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	// --------------------------------------------------------------
	// Run, output and read behaviour
	// --------------------------------------------------------------
	property p_stop_a;
		(!ctrl_a[RUN_BIT]) [*2] |-> count_reg_a == CNT_ZERO;
	endproperty
	a_stop_a: assert property (p_stop_a)
		else $error("count a not cleared while stopped");
	property p_stop_b;
		(!ctrl_b[RUN_BIT] && !ctrl_b[CASC_BIT]) [*2]
			|-> count_reg_b == CNT_ZERO;
	endproperty
	a_stop_b: assert property (p_stop_b)
		else $error("count b not cleared while stopped");
	property p_pwm_idle;
		(ctrl_a[PWM_BIT] && ctrl_a[OE_BIT] && !ctrl_a[RUN_BIT]) [*3]
			|-> wave_out_a == !ctrl_a[ALV_BIT];
	endproperty
	a_pwm_idle: assert property (p_pwm_idle)
		else $error("pwm output not inactive while stopped");
	property p_oe_off;
		(!ctrl_a[OE_BIT]) [*2] |-> !wave_out_a;
	endproperty
	a_oe_off: assert property (p_oe_off)
		else $error("output a driven while disabled");
	// A read must freeze the count, even across several cycles
	property p_rd_hold;
		(ctrl_a[RUN_BIT] && count_rd_a) [*3] |-> $stable(count_reg_a);
	endproperty
	a_rd_hold: assert property (p_rd_hold)
		else $error("count a moved during read");
	property p_irq_clear;
		match_irq_a && ctrl_a[RUN_BIT] && !ctrl_b[CASC_BIT]
			|-> count_reg_a == CNT_ZERO;
	endproperty
	a_irq_clear: assert property (p_irq_clear)
		else $error("irq a without clear or overflow");
	// --------------------------------------------------------------
	// Cascade and compare read-back
	// --------------------------------------------------------------
	property p_casc_clear;
		match_irq_a && ctrl_b[CASC_BIT]
			|-> count_reg_a == CNT_ZERO && count_reg_b == CNT_ZERO;
	endproperty
	a_casc_clear: assert property (p_casc_clear)
		else $error("cascade match did not clear both");
	property p_casc_carry;
		ctrl_b[CASC_BIT] && $changed(count_reg_b)
			|-> count_reg_a == CNT_ZERO;
	endproperty
	a_casc_carry: assert property (p_casc_carry)
		else $error("upper byte moved without wrap");
	property p_cmp_rd;
		compare_wr_a && !ctrl_a[RUN_BIT]
			|-> ##2 compare_a == $past(compare_wdata, 2);
	endproperty
	a_cmp_rd: assert property (p_cmp_rd)
		else $error("compare a read-back wrong");
endmodule : dt8_asserts

bind dt8_timer dt8_asserts u_asserts (
	.clk(clk),
	.sys_rst(sys_rst),
	.ctrl_a(ctrl_a),
	.ctrl_b(ctrl_b),
	.compare_wr_a(compare_wr_a),
	.compare_wdata(compare_wdata),
	.count_rd_a(count_rd_a),
	.count_reg_a(count_reg_a),
	.count_reg_b(count_reg_b),
	.compare_a(compare_a),
	.match_irq_a(match_irq_a),
	.wave_out_a(wave_out_a)
);

// ==== tb_top.sv ====
// Self-checking bench for the dual 8-bit timer.
// Assumes the timer, its checker and the event pin model.
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import dt8_pkg::*;
`define CHK(nm, ex, sn) begin \
	comparisons++; \
	if ((ex) !== (sn)) begin \
		err_count++; \
		$display("[FAIL] %s expected %0h seen %0h", nm, ex, sn); \
	end \
end
	logic      clk = 1'b0;
	logic      sys_rst = 1'b1;
	dt8_byte_t ctrl_a = 8'h00;
	dt8_byte_t ctrl_b = 8'h00;
	dt8_csel_t clock_select_a = CSEL_RISE;
	dt8_csel_t clock_select_b = CSEL_FALL;
	logic      compare_wr_a = 1'b0;
	logic      compare_wr_b = 1'b0;
	dt8_byte_t compare_wdata = 8'h00;
	logic      count_rd_a = 1'b0;
	logic      count_rd_b = 1'b0;
	logic      req_a = 1'b0;
	logic      req_b = 1'b0;
	wire       event_in_a;
	wire       event_in_b;
	dt8_byte_t count_reg_a;
	dt8_byte_t count_reg_b;
	dt8_byte_t compare_a;
	dt8_byte_t compare_b;
	logic      match_irq_a;
	logic      match_irq_b;
	logic      wave_out_a;
	logic      wave_out_b;
	int        err_count = 0;
	int        comparisons = 0;
	int        irq_a = 0;
	int        irq_b = 0;
	int        n, c, t, p;
	int        dv[6] = '{4, 8, 16, 32, 128, 512};

	dt8_timer DUT (.clk(clk), .sys_rst(sys_rst), .ctrl_a(ctrl_a),
		.ctrl_b(ctrl_b), .clock_select_a(clock_select_a),
		.clock_select_b(clock_select_b), .compare_wr_a(compare_wr_a),
		.compare_wr_b(compare_wr_b), .compare_wdata(compare_wdata),
		.count_rd_a(count_rd_a), .count_rd_b(count_rd_b),
		.event_in_a(event_in_a), .event_in_b(event_in_b),
		.count_reg_a(count_reg_a), .count_reg_b(count_reg_b),
		.compare_a(compare_a), .compare_b(compare_b),
		.match_irq_a(match_irq_a), .match_irq_b(match_irq_b),
		.wave_out_a(wave_out_a), .wave_out_b(wave_out_b));
	dt8_event_src u_src_a (.clk(clk), .req(req_a), .pin(event_in_a));
	dt8_event_src u_src_b (.clk(clk), .req(req_b), .pin(event_in_b));

	// Clock and interrupt tallies for the model comparison
	initial begin
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (match_irq_a === 1'b1) irq_a++;
		if (match_irq_b === 1'b1) irq_b++;
	end
	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : step
	// Each call waits out sync and irq latency before returning
	task automatic edges(input bit b, input int k);
		repeat (k) begin
			req_a = !b;
			req_b = b;
			step(1);
			req_a = 1'b0;
			req_b = 1'b0;
			step(13);
		end
	endtask : edges
	task automatic wcmp(input bit b, input dt8_byte_t v);
		compare_wdata = v;
		compare_wr_a = !b;
		compare_wr_b = b;
		step(1);
		compare_wr_a = 1'b0;
		compare_wr_b = 1'b0;
		step(1);
	endtask : wcmp
	task automatic tally_and_finish;
		if (err_count == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : tally_and_finish
	// Hang guard, far beyond the expected run length
	initial begin
		repeat (60000) @(posedge clk);
		err_count++;
		tally_and_finish();
	end

	// Main sequence
	initial begin
		c = $urandom(32'hCC16);
		step(6);
		sys_rst = 1'b0;
		step(1);
		`CHK("reset", 34'h0, {count_reg_a, count_reg_b, compare_a,
			compare_b, wave_out_a, wave_out_b})
		for (int b = 0; b < 2; b++) begin
			c = $urandom_range(1, 9);
			n = $urandom_range(10, 40);
			// Preset the output high while stopped, then run as square wave
			if (b) ctrl_b = 8'h08;
			else ctrl_a = 8'h08;
			wcmp(b[0], 8'(c));
			irq_a = 0;
			irq_b = 0;
			if (b) ctrl_b = 8'h81;
			else ctrl_a = 8'h81;
			edges(b[0], n);
			`CHK("count", 8'(n % (c + 1)), b ? count_reg_b : count_reg_a)
			`CHK("irq", n / (c + 1), b ? irq_b : irq_a)
			`CHK("compare", 8'(c), b ? compare_b : compare_a)
			`CHK("square", 1'(1 + n / (c + 1)), b ? wave_out_b : wave_out_a)
			ctrl_a = 8'h00;
			ctrl_b = 8'h00;
			step(2);
			`CHK("stop", 16'h0000, {count_reg_b, count_reg_a})
		end
		wcmp(1'b0, CNT_MAX);
		for (int k = 0; k < 6; k++) begin
			clock_select_a = dt8_csel_t'(k + 2);
			ctrl_a = 8'h80;
			step(6 * dv[k]);
			t = count_reg_a;
			ctrl_a = 8'h00;
			step(2);
			`CHK("divider", 1'b1, (t >= 5 && t <= 7))
		end
		clock_select_a = CSEL_DIV4;
		clock_select_b = CSEL_DIV8;
		ctrl_a = 8'h80;
		ctrl_b = 8'h80;
		step(20);
		count_rd_a = 1'b1;
		count_rd_b = 1'b1;
		step(2);
		t = count_reg_a;
		p = count_reg_b;
		step(40);
		`CHK("read run", 1'b1, (t > 0 && p > 0))
		`CHK("read hold", 8'(t), count_reg_a)
		`CHK("read hold b", 8'(p), count_reg_b)
		count_rd_a = 1'b0;
		count_rd_b = 1'b0;
		ctrl_a = 8'h00;
		// Cascade: upper byte one, lower byte random
		c = $urandom_range(0, 15);
		clock_select_a = CSEL_RISE;
		ctrl_b = 8'h10;
		wcmp(1'b0, 8'(c));
		wcmp(1'b1, CNT_ONE);
		ctrl_b = 8'h90;
		step(1);
		ctrl_a = 8'h80;
		irq_a = 0;
		irq_b = 0;
		n = 300;
		p = 256 + c + 1;
		edges(1'b0, n);
		`CHK("cascade", 16'(n % p), {count_reg_b, count_reg_a})
		`CHK("casc irq a", n / p, irq_a)
		`CHK("casc irq b", n / p, irq_b)
		ctrl_a = 8'h00;
		step(2);
		`CHK("casc stop", 16'h0000, {count_reg_b, count_reg_a})
		ctrl_a = 8'h80;
		edges(1'b0, 5);
		`CHK("casc run", 16'h0005, {count_reg_b, count_reg_a})
		ctrl_a = 8'h00;
		ctrl_b = 8'h00;
		// PWM, active high, output enabled
		c = $urandom_range(20, 200);
		ctrl_a = 8'h43;
		wcmp(1'b0, 8'(c));
		ctrl_a = 8'hC3;
		irq_a = 0;
		edges(1'b0, 3);
		`CHK("pwm start", 1'b0, wave_out_a)
		edges(1'b0, 253);
		`CHK("pwm irq", 1, irq_a)
		`CHK("pwm active", 1'b1, wave_out_a)
		edges(1'b0, c + 5);
		`CHK("pwm inactive", 1'b0, wave_out_a)
		`CHK("pwm count", 8'(c + 5), count_reg_a)
		ctrl_a = 8'h43;
		step(3);
		`CHK("pwm stop", 1'b0, wave_out_a)
		tally_and_finish();
	end
endmodule : tb_top
